//--- rtl/ppip_pkg.sv
package ppip_pkg;

    // register byte offsets on the ahb-lite bus
    localparam logic [7:0] PPIP_OFS_STATUS  = 8'h00;
    localparam logic [7:0] PPIP_OFS_DATA    = 8'h04;
    localparam logic [7:0] PPIP_OFS_DECODE  = 8'h08;
    localparam logic [7:0] PPIP_OFS_IRQ_ST  = 8'h0c;
    localparam logic [7:0] PPIP_OFS_IRQ_MSK = 8'h10;

    // decoder register codes
    localparam logic [7:0] PPIP_CODE_READ = 8'h01;
    localparam logic [7:0] PPIP_CODE_ACK  = 8'h02;

    // status register field positions
    localparam int PPIP_ST_BYTE_WAIT_N = 0;
    localparam int PPIP_ST_BUSY        = 1;
    localparam int PPIP_ST_ACK_N       = 2;
    localparam int PPIP_ST_MODE        = 3;
    localparam int PPIP_ST_STROBE_N    = 4;

    // interrupt status field positions
    localparam int PPIP_IRQ_BYTE = 0;
    localparam int PPIP_IRQ_ACK  = 1;

    // reset values
    localparam logic [7:0] PPIP_DATA_RST = 8'h00;
    localparam logic [1:0] PPIP_MSK_RST  = 2'h0;

    // acknowledge pulse width: least 1 us at 200 mhz (5 ns)
    localparam int PPIP_CLK_PERIOD_NS = 5;
    localparam int PPIP_ACK_PULSE_NS  = 1000;
    localparam int PPIP_ACK_CYCLES    =
        (PPIP_ACK_PULSE_NS + PPIP_CLK_PERIOD_NS - 1) / PPIP_CLK_PERIOD_NS;
    localparam int PPIP_ACK_CNT_W     = 8;

    // host-side parallel pins grouped together
    typedef struct packed {
        logic [7:0] data;
        logic       strobe_n;
        logic       protocol_select_pin;
    } ppip_host_in_s;

    typedef struct packed {
        logic busy;
        logic host_ack_n;
    } ppip_host_out_s;

    // acknowledge sequencer states
    typedef enum logic [1:0] {
        PPIP_ACK_IDLE,
        PPIP_ACK_LOW,
        PPIP_ACK_WAIT_STB
    } ppip_ack_e;

endpackage

//--- rtl/ppip_ahb_slave.sv
module ppip_ahb_slave
    import ppip_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave side
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    // decoded data phase strobes
    output logic             wr_en,
    output logic             rd_en,
    output logic [7:0]       ofs
);

    // captured address phase
    logic       ph_wr;
    logic       ph_rd;
    logic [7:0] ph_ofs;

    // transfer starts on nonseq or seq with hready
    wire start = hsel & hready & htrans[1];

    // hold address phase for the single-cycle data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr  <= 1'b0;
            ph_rd  <= 1'b0;
            ph_ofs <= 8'h00;
        end else begin
            ph_wr  <= start & hwrite;
            ph_rd  <= start & ~hwrite;
            ph_ofs <= haddr[7:0];
        end
    end

    // zero wait states, so every data phase completes at once
    assign wr_en = ph_wr;
    assign rd_en = ph_rd;
    assign ofs   = ph_ofs;

endmodule

//--- rtl/ppip_strobe_det.sv
module ppip_strobe_det
    import ppip_pkg::*;
(
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // strobe level from the host
    input  wire logic strobe_n,
    // edge pulses
    output logic      fall,
    output logic      rise
);

    // previous strobe level, idle high
    logic prev;

    // inputs are synchronous, one register finds the edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev <= 1'b1;
        end else begin
            prev <= strobe_n;
        end
    end

    assign fall = prev & ~strobe_n;
    assign rise = ~prev & strobe_n;

endmodule

//--- rtl/ppip_top.sv
module ppip_top
    import ppip_pkg::*;
(
    // clock and reset
    input  wire logic           hclk,
    input  wire logic           hresetn,
    // ahb-lite slave
    input  wire logic           hsel,
    input  wire logic [31:0]    haddr,
    input  wire logic [1:0]     htrans,
    input  wire logic [2:0]     hsize,
    input  wire logic           hwrite,
    input  wire logic           hready,
    input  wire logic [31:0]    hwdata,
    output logic      [31:0]    hrdata,
    output logic                hreadyout,
    output logic                hresp,
    // parallel host port
    input  wire ppip_host_in_s  host_in,
    output ppip_host_out_s      host_out,
    // processor side strobe and interrupt
    output logic                data_read_n,
    output logic                irq
);

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    // the slave never stretches a transfer, so every access ends after
    // one data phase; hsize is not decoded because only whole words are
    // used and each register sits alone in its own aligned word

    logic       wr_en;                  // data phase write
    logic       rd_en;                  // data phase read
    logic [7:0] ofs;                    // data phase offset

    ppip_ahb_slave u_bus (
        .hclk    (hclk),
        .hresetn (hresetn),
        .hsel    (hsel),
        .haddr   (haddr),
        .htrans  (htrans),
        .hwrite  (hwrite),
        .hready  (hready),
        .wr_en   (wr_en),
        .rd_en   (rd_en),
        .ofs     (ofs)
    );

    // named register selects
    // only the low byte of the address is decoded, so the block
    // repeats through its address window
    wire sel_status = (ofs == PPIP_OFS_STATUS);
    wire sel_data   = (ofs == PPIP_OFS_DATA);
    wire sel_decode = (ofs == PPIP_OFS_DECODE);
    wire sel_irq_st = (ofs == PPIP_OFS_IRQ_ST);
    wire sel_msk    = (ofs == PPIP_OFS_IRQ_MSK);

    // decoder register commands
    wire cmd_read = wr_en & sel_decode & (hwdata[7:0] == PPIP_CODE_READ);
    wire cmd_ack  = wr_en & sel_decode & (hwdata[7:0] == PPIP_CODE_ACK);

    // a direct read of the data register acts as the read code too
    // both paths end in the same strobe, so software may use either;
    // a read of any other offset has no side effect at all
    wire data_rd  = cmd_read | (rd_en & sel_data);

    ////////////////////////////////////////////////////////////////////////
    // strobe edges and mode

    // host pins arrive already synchronous to hclk, so a single stage
    // of history is enough to find both edges of the strobe; a host on
    // a foreign clock would need a two-stage synchroniser in front
    logic stb_fall;                     // strobe went low
    logic stb_rise;                     // strobe returned high

    ppip_strobe_det u_stb (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .strobe_n (host_in.strobe_n),
        .fall     (stb_fall),
        .rise     (stb_rise)
    );

    // interlocked mode while the select pin is high; changing the pin
    // in the middle of a transfer is not supported
    wire protocol_select = host_in.protocol_select_pin;

    ////////////////////////////////////////////////////////////////////////
    // data latch and byte-waiting flag

    logic [7:0] data_latch;             // held byte
    logic       byte_wait;              // high when a byte waits
    logic       busy;                   // busy mode output
    logic       ack_n;                  // acknowledge to host

    // interlocked: latch transparent while strobe low; busy: rise edge
    wire lat_open = protocol_select & ~host_in.strobe_n;
    wire capture  = ~protocol_select & stb_rise & ~busy;
    // interlocked byte arrives on the falling strobe
    wire arrive   = (protocol_select & stb_fall) | capture;

    // latch data; a transparent latch is modelled by sampling each cycle
    // while the strobe is low, which keeps the design free of real
    // latches at the cost of one cycle of delay behind the pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_latch <= PPIP_DATA_RST;
        end else if (lat_open | capture) begin
            data_latch <= host_in.data;
        end
    end

    // flag sets on arrival; arrival wins over the read clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            byte_wait <= 1'b0;
        end else if (arrive) begin
            // a byte landing in the read cycle must not be lost
            byte_wait <= 1'b1;
        end else if (data_rd) begin
            byte_wait <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // busy output

    logic       ack_n_d;                // acknowledge one cycle ago

    // delayed ack finds the first low cycle of the pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack_n_d <= 1'b1;
        end else begin
            ack_n_d <= ack_n;
        end
    end

    // only the leading edge of the ack pulse clears busy: a host that
    // sees busy drop may strobe the next byte while ack is still low,
    // and that byte must keep busy high until its own acknowledge
    wire ack_lead = ~protocol_select & ~ack_n & ack_n_d;

    // busy register set by capture, cleared by the ack pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy <= 1'b0;
        end else if (capture) begin
            busy <= 1'b1;
        end else if (ack_lead) begin
            busy <= 1'b0;
        end
    end

    // combinational term raises busy in the capture cycle itself;
    // ignoring strobes while busy protects against a rude host
    wire busy_out = busy | capture;

    ////////////////////////////////////////////////////////////////////////
    // acknowledge sequencer

    ppip_ack_e                 ack_state;
    ppip_ack_e                 next_ack_state;
    logic [PPIP_ACK_CNT_W-1:0] ack_cnt;     // pulse width count
    logic [PPIP_ACK_CNT_W-1:0] next_ack_cnt;

    localparam logic [PPIP_ACK_CNT_W-1:0] ACK_LAST =
        PPIP_ACK_CNT_W'(PPIP_ACK_CYCLES - 1);

    // interlocked: ack stays low until the host raises strobe;
    // busy mode: fixed-width low pulse
    // an ack code that arrives while a pulse runs is dropped, so a
    // double write cannot stretch or restart the pulse; the mode is
    // read only when the pulse starts
    always_comb begin
        next_ack_state = ack_state;
        next_ack_cnt   = ack_cnt;
        unique case (ack_state)
            PPIP_ACK_IDLE: begin
                if (cmd_ack) begin
                    next_ack_cnt   = '0;
                    next_ack_state = protocol_select ? PPIP_ACK_WAIT_STB
                                                     : PPIP_ACK_LOW;
                end
            end
            PPIP_ACK_LOW: begin
                next_ack_cnt = ack_cnt + 1'b1;
                if (ack_cnt == ACK_LAST) begin
                    next_ack_state = PPIP_ACK_IDLE;
                end
            end
            PPIP_ACK_WAIT_STB: begin
                // host answers by raising strobe, ending the handshake
                if (host_in.strobe_n) begin
                    next_ack_state = PPIP_ACK_IDLE;
                end
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack_state <= PPIP_ACK_IDLE;
            ack_cnt   <= '0;
        end else begin
            ack_state <= next_ack_state;
            ack_cnt   <= next_ack_cnt;
        end
    end

    // ack low while not idle; driven from the next state so the pin
    // falls at the same edge as the state changes, with no glitches
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack_n <= 1'b1;
        end else begin
            ack_n <= (next_ack_state == PPIP_ACK_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data-read strobe

    // one-cycle low pulse per read command; back-to-back reads merge
    // into one longer pulse, so software leaves a gap between them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_read_n <= 1'b1;
        end else begin
            data_read_n <= ~data_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts

    logic [1:0] irq_st;                 // sticky events
    logic [1:0] irq_msk;                // enables

    wire [1:0] irq_set = {ack_n & (next_ack_state != PPIP_ACK_IDLE), arrive};
    wire [1:0] irq_clr = (wr_en & sel_irq_st) ? hwdata[1:0] : 2'h0;

    // bit 0 marks a byte arrival, bit 1 the start of an acknowledge;
    // set wins over a write-one clear in the same cycle, so an event
    // that lands during the clear write is never lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_st <= 2'h0;
        end else begin
            irq_st <= (irq_st & ~irq_clr) | irq_set;
        end
    end

    // mask register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_msk <= PPIP_MSK_RST;
        end else if (wr_en & sel_msk) begin
            irq_msk <= hwdata[1:0];
        end
    end

    // level output, stays high until software clears the cause
    assign irq = |(irq_st & irq_msk);

    ////////////////////////////////////////////////////////////////////////
    // read mux and outputs

    // status word, flag shown active low as the processor expects
    wire [31:0] status_word = {27'h0, host_in.strobe_n, protocol_select,
                               ack_n, busy_out, ~byte_wait};

    // unmapped offsets read zero, and nothing is driven outside the
    // read data phase, so a stray read shows an idle bus
    assign hrdata = ~rd_en     ? 32'h0 :
                    sel_status ? status_word :
                    sel_data   ? {24'h0, data_latch} :
                    sel_irq_st ? {30'h0, irq_st} :
                    sel_msk    ? {30'h0, irq_msk} : 32'h0;

    // zero wait states and always an okay response
    assign hreadyout           = 1'b1;
    assign hresp               = 1'b0;
    assign host_out.busy       = busy_out;
    assign host_out.host_ack_n = ack_n;

endmodule

//--- bench/ppip_monitor.sv
module ppip_monitor
    import ppip_pkg::*;
(
    // bus side
    input wire logic           hclk,
    input wire logic           hresetn,
    input wire logic           hsel,
    input wire logic [1:0]     htrans,
    input wire logic           hwrite,
    input wire logic           hready,
    // host and processor side
    input wire ppip_host_in_s  host_in,
    input wire ppip_host_out_s host_out,
    input wire logic           data_read_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////////////
    wire logic   il   = host_in.protocol_select_pin;  // mode in use
    logic        rd_ph;                               // read data phase
    logic        wr_ph;                               // write data phase
    logic [15:0] low_cnt;                             // ack low run
    // phase trackers, so strobes can be tied back to bus accesses
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ph   <= 1'b0;
            wr_ph   <= 1'b0;
            low_cnt <= 16'h0;
        end else begin
            rd_ph   <= hsel & hready & htrans[1] & ~hwrite;
            wr_ph   <= hsel & hready & htrans[1] & hwrite;
            low_cnt <= host_out.host_ack_n ? 16'h0 : low_cnt + 16'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////
    ack_width_a: assert property (!il && host_out.host_ack_n &&
        low_cnt != 16'h0 |-> low_cnt == PPIP_ACK_CYCLES)
        else $error("busy mode ack pulse has wrong width");
    busy_clear_a: assert property (!il && $fell(host_out.host_ack_n)
        |-> ##[1:2] !host_out.busy)
        else $error("ack pulse did not clear busy");
    busy_rise_a: assert property (!il && $rose(host_in.strobe_n) &&
        !$past(host_out.busy) |-> host_out.busy)
        else $error("busy not raised on capture");
    busy_hold_a: assert property (!il && host_out.busy &&
        host_out.host_ack_n |=> host_out.busy)
        else $error("busy dropped without ack");
    il_release_a: assert property (il && !host_out.host_ack_n &&
        host_in.strobe_n |-> ##[1:3] host_out.host_ack_n)
        else $error("interlocked ack held after strobe high");
    ack_cause_a: assert property ($fell(host_out.host_ack_n)
        |-> $past(wr_ph) || $past(wr_ph, 2))
        else $error("ack started without a decoder write");
    rd_cause_a: assert property ($fell(data_read_n) |->
        $past(wr_ph) || $past(rd_ph) || $past(wr_ph, 2) || $past(rd_ph, 2))
        else $error("data read strobe without bus access");
    rd_pulse_a: assert property (!data_read_n |=> data_read_n)
        else $error("data read strobe longer than one cycle");
    // main scenarios reached
    cover property (!il && $rose(host_out.busy));
    cover property (il && $fell(host_out.host_ack_n));
    cover property ($fell(data_read_n));
endmodule

bind ppip_top ppip_monitor i_ppip_monitor (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .host_in(host_in), .host_out(host_out), .data_read_n(data_read_n));

//--- bench/ppip_host_model.sv
module ppip_host_model
    import ppip_pkg::*;
(
    // clock
    input  wire logic           hclk,
    // device answers
    input  wire ppip_host_out_s host_out,
    // host drive
    output ppip_host_in_s       host_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ack_lo;  // ack seen low, sampled off the edge
    initial host_in = {8'h00, 1'b1, 1'b0};
    always @(negedge hclk) ack_lo = (host_out.host_ack_n === 1'b0);
    // interlocked: answer ack by raising strobe, then move data on
    always @(posedge hclk) begin
        if (host_in.protocol_select_pin && !host_in.strobe_n && ack_lo) begin
            host_in.strobe_n <= 1'b1;
        end else if (host_in.protocol_select_pin && ack_lo) begin
            host_in.data <= ~host_in.data; // next byte only after strobe
        end
    end
    // mode pin
    task mode(input logic m);
        host_in.protocol_select_pin <= m;
    endtask
    // change the data lines in place, strobe untouched
    task move(input logic [7:0] d);
        host_in.data <= d;
    endtask
    // one byte; rude ignores busy, to test refusal
    task send(input logic [7:0] d, input logic rude);
        logic b;
        int   n;
        n = 0;
        do begin
            @(negedge hclk);
            b = host_out.busy;
            @(posedge hclk);
            n++;
        end while (b === 1'b1 && !rude && n < 1000);
        host_in.data     <= d;
        host_in.strobe_n <= 1'b0;
        repeat (3) @(posedge hclk);
        // interlocked: strobe stays low until ack comes
        if (!host_in.protocol_select_pin) begin
            host_in.strobe_n <= 1'b1;
            repeat (2) @(posedge hclk);
            host_in.data <= ~d;
            @(posedge hclk);
        end
    endtask
endmodule

//--- bench/ppip_tb_top.sv
module ppip_tb_top
    import ppip_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic           hclk;
    logic           hresetn;
    logic           hsel;
    logic [31:0]    haddr;
    logic [1:0]     htrans;
    logic [2:0]     hsize;
    logic           hwrite;
    logic [31:0]    hwdata;
    logic [31:0]    hrdata;
    logic           hreadyout;
    logic           hresp;
    logic           data_read_n;
    logic           irq;
    ppip_host_in_s  host_in;
    ppip_host_out_s host_out;
    int             err_count;
    int             compares;
    int             cyc;
    logic           ack_seen;
    // hready loops back from the one slave
    ppip_top i_ppip_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hsize(hsize), .hwrite(hwrite),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .host_in(host_in),
        .host_out(host_out), .data_read_n(data_read_n), .irq(irq));
    ppip_host_model i_ppip_host_model (.hclk(hclk), .host_out(host_out),
        .host_in(host_in));
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    // hang guard, far above the thousand or so cycles needed
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    always @(posedge hclk) if (host_out.host_ack_n === 1'b0) ack_seen <= 1'b1;
    ////////////////////////////////////////////////////////////////////
    task give_verdict();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // wait one bus phase; data sampled just before its closing edge
    task ph(output logic [31:0] rd);
        logic r;
        do begin
            @(negedge hclk);
            rd = hrdata;
            r = hreadyout;
            @(posedge hclk);
        end while (r !== 1'b1);
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hsize  <= 3'h2;
        hwrite <= w;
        ph(rd);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        ph(rd);
    endtask
    task rd_reg(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(nm, e, r);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    // status word: strobe, mode, ack, busy, byte-waiting (low active)
    function automatic logic [31:0] st_exp(input logic m, input logic fl);
        return {27'h0, ~m, m, 1'b1, ~m, fl};
    endfunction
    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        logic [7:0]  d;
        logic [1:0]  mk;
        logic        m;
        int          n;
        void'($urandom(32'h83dd598d));
        {hresetn, hsel, haddr, htrans, hsize, hwrite, hwdata} = '0;
        {err_count, compares, cyc, ack_seen} = '0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("pins", 32'h6, {host_out, data_read_n, irq});
        chk("hresp", 32'h0, {31'h0, hresp});
        rd_reg(PPIP_OFS_STATUS, 32'h15, "status");
        rd_reg(8'h14, 32'h0, "unmapped");
        rd_reg(PPIP_OFS_DATA, 32'h0, "latch");
        for (int i = 0; i < 8; i++) begin
            m = i[0];
            d = 8'($urandom);
            mk = 2'($urandom);
            i_ppip_host_model.mode(m);
            wr(PPIP_OFS_IRQ_MSK, {30'h0, mk});
            rd_reg(PPIP_OFS_IRQ_MSK, {30'h0, mk}, "mask");
            i_ppip_host_model.send(d, 1'b0);
            // a strobe while busy must be ignored
            if (i == 2) i_ppip_host_model.send(~d, 1'b1);
            // interlocked latch must follow data moved under a low strobe
            if (i == 3) begin
                i_ppip_host_model.move(~d);
                d = ~d;
            end
            n = 0;
            do begin
                bus(1'b0, PPIP_OFS_STATUS, 32'h0, r);
                n++;
            end while (r[0] !== 1'b0 && n < 20);
            chk("status", st_exp(m, 1'b0), r);
            chk("irq", {31'h0, mk[0]}, {31'h0, irq});
            wr(PPIP_OFS_DECODE, {24'h0, PPIP_CODE_READ});
            rd_reg(PPIP_OFS_STATUS, st_exp(m, 1'b1), "flag");
            rd_reg(PPIP_OFS_DATA, {24'h0, d}, "data");
            ack_seen = 1'b0;
            wr(PPIP_OFS_DECODE, {24'h0, PPIP_CODE_ACK});
            n = 0;
            while ((host_out !== 2'b01 || host_in.strobe_n !== 1'b1)
                   && n < 600) begin
                @(posedge hclk);
                n++;
            end
            chk("ack", 32'h1, {31'h0, ack_seen});
            chk("idle", 32'h1, {30'h0, host_out});
            chk("irq_ack", {31'h0, |mk}, {31'h0, irq});
            rd_reg(PPIP_OFS_IRQ_ST, 32'h3, "irq_st");
            wr(PPIP_OFS_IRQ_ST, 32'h3);
            rd_reg(PPIP_OFS_IRQ_ST, 32'h0, "irq_clr");
            chk("irq_off", 32'h0, {31'h0, irq});
        end
        // second reset in mid-run
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("pins2", 32'h6, {host_out, data_read_n, irq});
        rd_reg(PPIP_OFS_STATUS, 32'h1d, "status2");
        rd_reg(PPIP_OFS_DATA, 32'h0, "latch2");
        give_verdict();
    end
endmodule
